// file: design/emi_core.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - one configuration bit picks shared or separate address/data pins.
// - mux select 0 means shared pins, 1 means separate pins.
// - multiplexed: data and low address byte share the eight ad pins.
// - multiplexed: latch strobe high while low address on ad; fall starts phase two.
// - multiplexed phase two: ad pins carry data while read/write strobe asserted.
// - non-multiplexed: separate address and data pins, no latch strobe.
// - mode 00: all moves on-chip, address wraps to fitted RAM size.
// - internal mode: 8-bit uses page and byte pointer, 16-bit uses data pointer.
// - split modes: below RAM size on-chip, above off-chip; page decides 8-bit.
// - split without bank: 8-bit off-chip leaves upper pins undriven, low from pointer.
// - split modes: 16-bit decides from data pointer, drives all sixteen pins.
// - split with bank: 8-bit off-chip drives page high, pointer low.
// - mode 11: all moves off-chip, on-chip RAM invisible.
// - external mode: 8-bit ignores page, upper pins undriven, low from pointer.
// - external mode: 16-bit drives full data pointer on sixteen pins.
// - setup, hold, strobe and latch widths programmable in whole cycles.
// - off-chip access lasts programmed timing plus four cycles.
// - multiplexed access spends at least two more cycles on latch phases.
// - after reset setup and hold settings are at maximum.
// - latch width codes 00..11 give 1..4 cycles high and low.
// - setup and hold codes give 0..3 cycles each.
// - strobe width is field value plus one, 1..16 cycles.
module emi_core (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 mux_mode_select,
  input  wire emi_pkg::emi_mode_t   memory_mode_select,
  input  wire logic [1:0]           latch_strobe_width_select,
  input  wire logic                 timing_load,
  input  wire logic [7:0]           timing_wdata,
  output logic      [7:0]           emif_timing_register,
  input  wire logic [7:0]           external_data_ram_page_register,
  input  wire logic [7:0]           byte_pointer,
  input  wire logic [15:0]          data_pointer,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic                 req_write,
  input  wire logic                 req_wide,
  input  wire logic [7:0]           req_wdata,
  output logic                      rsp_valid,
  output logic      [7:0]           rsp_rdata,
  output logic      [7:0]           addr_hi_out,
  output logic                      addr_hi_oe,
  output logic      [7:0]           addr_lo_out,
  output logic                      addr_lo_oe,
  output logic      [7:0]           ad_out,
  output logic                      ad_oe,
  input  wire logic [7:0]           ad_in,
  output logic                      ale,
  output logic                      rd_n,
  output logic                      wr_n
);
  import emi_pkg::*;

  typedef struct packed {
    emi_state_t  state;
    logic [3:0]  cnt;
    logic [7:0]  timing;
    logic [15:0] addr;
    logic        hi_en;
    logic        mux;
    logic        write;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rsp;
  } emi_core_t;

  emi_core_t r;
  emi_core_t next_r;

  logic [1:0]  setup_sel;
  logic [3:0]  strobe_sel;
  logic [1:0]  hold_sel;
  logic [15:0] ea;
  logic        go_int;
  logic        fire;
  logic        active;
  emi_state_t  after_ale;
  logic [3:0]  after_ale_cnt;
  logic [7:0]  mem_rdata;

  assign setup_sel  = r.timing[EMI_TC_SETUP_LSB +: 2];
  assign strobe_sel = r.timing[EMI_TC_STROBE_LSB +: 4];
  assign hold_sel   = r.timing[EMI_TC_HOLD_LSB +: 2];

  // ************************************************************
  // address formation and on/off-chip decision
  // ************************************************************
  assign ea = req_wide ? data_pointer : {external_data_ram_page_register, byte_pointer};
  always_comb begin
    case (memory_mode_select)
      EMI_MODE_INT_ONLY: go_int = 1'b1;
      EMI_MODE_EXT_ONLY: go_int = 1'b0;
      default:           go_int = (ea[15:EMI_EXTERNAL_DATA_RAM_AW] == 4'h0);
    endcase
  end

  assign req_ready = (r.state == EMI_ST_IDLE);
  assign fire      = req_valid && req_ready;

  // zero setup skips straight to the strobe
  always_comb begin
    if (setup_sel != 2'h0) begin
      after_ale     = EMI_ST_SETUP;
      after_ale_cnt = {2'h0, setup_sel} - 4'h1;
    end else begin
      after_ale     = EMI_ST_STROBE;
      after_ale_cnt = strobe_sel;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    next_r     = r;
    next_r.rsp = 1'b0;
    if (timing_load) begin
      next_r.timing = timing_wdata;
    end
    case (r.state)
      EMI_ST_IDLE: begin
        if (fire) begin
          next_r.write = req_write;
          next_r.wdata = req_wdata;
          next_r.mux   = ~mux_mode_select;
          next_r.hi_en = req_wide || (memory_mode_select == EMI_MODE_SPLIT_BS);
          next_r.cnt   = 4'h0;
          if (go_int) begin
            next_r.addr  = {4'h0, ea[EMI_EXTERNAL_DATA_RAM_AW-1:0]};
            next_r.state = EMI_ST_INT;
          end else if (!req_wide && (memory_mode_select == EMI_MODE_EXT_ONLY)) begin
            next_r.addr  = {8'h00, byte_pointer};
            next_r.state = EMI_ST_LEAD;
          end else begin
            next_r.addr  = ea;
            next_r.state = EMI_ST_LEAD;
          end
        end
      end
      EMI_ST_INT: begin
        next_r.state = EMI_ST_INT_DONE;
      end
      EMI_ST_INT_DONE: begin
        next_r.rdata = r.write ? r.rdata : mem_rdata;
        next_r.rsp   = 1'b1;
        next_r.state = EMI_ST_IDLE;
      end
      EMI_ST_LEAD: begin
        if (r.mux) begin
          next_r.state = EMI_ST_ALE_HI;
          next_r.cnt   = {2'h0, latch_strobe_width_select};
        end else begin
          next_r.state = after_ale;
          next_r.cnt   = after_ale_cnt;
        end
      end
      EMI_ST_ALE_HI: begin
        if (r.cnt == 4'h0) begin
          next_r.state = EMI_ST_ALE_LO;
          next_r.cnt   = {2'h0, latch_strobe_width_select};
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      EMI_ST_ALE_LO: begin
        if (r.cnt == 4'h0) begin
          next_r.state = after_ale;
          next_r.cnt   = after_ale_cnt;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      EMI_ST_SETUP: begin
        if (r.cnt == 4'h0) begin
          next_r.state = EMI_ST_STROBE;
          next_r.cnt   = strobe_sel;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      EMI_ST_STROBE: begin
        if (r.cnt == 4'h0) begin
          // sample at the last strobe cycle, data has had the full width to settle
          if (!r.write) begin
            next_r.rdata = ad_in;
          end
          if (hold_sel != 2'h0) begin
            next_r.state = EMI_ST_HOLD;
            next_r.cnt   = {2'h0, hold_sel} - 4'h1;
          end else begin
            next_r.state = EMI_ST_TAIL;
            next_r.cnt   = EMI_TAIL_CNT;
          end
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      EMI_ST_HOLD: begin
        if (r.cnt == 4'h0) begin
          next_r.state = EMI_ST_TAIL;
          next_r.cnt   = EMI_TAIL_CNT;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      EMI_ST_TAIL: begin
        if (r.cnt == 4'h0) begin
          next_r.state = EMI_ST_IDLE;
          next_r.rsp   = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      default: begin
        next_r.state = EMI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r        <= '0;
      r.state  <= EMI_ST_IDLE;
      r.timing <= EMI_TC_RST;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // on-chip data RAM
  // ************************************************************
  emi_external_data_ram u_external_data_ram (
    .clk_sys (clk_sys),
    .we      ((r.state == EMI_ST_INT) && r.write),
    .addr    (r.addr[EMI_EXTERNAL_DATA_RAM_AW-1:0]),
    .wdata   (r.wdata),
    .rdata   (mem_rdata)
  );

  // ************************************************************
  // pins
  // ************************************************************
  // on-chip states are not active, so nothing external moves
  assign active = (r.state != EMI_ST_IDLE) && (r.state != EMI_ST_INT)
                && (r.state != EMI_ST_INT_DONE);
  assign ale         = (r.state == EMI_ST_ALE_HI);
  assign rd_n        = ~((r.state == EMI_ST_STROBE) && !r.write);
  assign wr_n        = ~((r.state == EMI_ST_STROBE) && r.write);
  assign addr_hi_out = r.addr[15:8];
  assign addr_hi_oe  = active && r.hi_en;
  assign addr_lo_out = r.addr[7:0];
  assign addr_lo_oe  = active && !r.mux;
  // reads release ad once the latch holds the address
  assign ad_out      = (r.mux && ale) ? r.addr[7:0] : r.wdata;
  assign ad_oe       = active && (r.write || (r.mux && ale));
  assign rsp_valid   = r.rsp;
  assign rsp_rdata   = r.rdata;
  assign emif_timing_register = r.timing;

  // ************************************************************
  // checks
  // ************************************************************
  logic [5:0] dur;
  logic [4:0] ale_len;
  logic [4:0] stb_len;
  logic [5:0] want_dur;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dur     <= 6'h00;
      ale_len <= 5'h00;
      stb_len <= 5'h00;
    end else begin
      // counts the current state cycle too, so the last tail cycle sees the full length
      dur     <= (r.state == EMI_ST_LEAD) ? 6'h02 : (active ? dur + 6'h01 : 6'h00);
      ale_len <= ale ? ale_len + 5'h01 : 5'h00;
      stb_len <= (!rd_n || !wr_n) ? stb_len + 5'h01 : 5'h00;
    end
  end

  assign want_dur = {2'h0, EMI_OVERHEAD} + {4'h0, setup_sel} + {2'h0, strobe_sel} + 6'h01
                  + {4'h0, hold_sel}
                  + (r.mux ? {3'h0, latch_strobe_width_select, 1'b0} + 6'h02 : 6'h00);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_RESET_TIMING: assert property ($past(srst) |-> r.timing == EMI_TC_RST)
    else $error("timing not at maximum after reset");
  AST_INT_QUIET: assert property (!active |-> rd_n && wr_n && !ale && !addr_hi_oe && !addr_lo_oe)
    else $error("external pins touched outside an off-chip access");
  AST_NO_ALE_NONMUX: assert property (active && !r.mux |-> !ale && addr_lo_oe)
    else $error("latch strobe or missing low address in separate mode");
  AST_ALE_ADDR: assert property (ale |-> ad_oe && ad_out == r.addr[7:0] && !addr_lo_oe)
    else $error("low address not on shared pins with latch strobe");
  AST_MUX_DATA: assert property (r.mux && !wr_n |-> ad_oe && ad_out == r.wdata)
    else $error("write data missing on shared pins");
  AST_ALE_WIDTH: assert property ($fell(ale)
    |-> ale_len == {3'h0, latch_strobe_width_select} + 5'h01)
    else $error("latch strobe width wrong");
  AST_STROBE_WIDTH: assert property ($rose(rd_n & wr_n)
    |-> stb_len == {1'b0, strobe_sel} + 5'h01)
    else $error("strobe width wrong");
  AST_DURATION: assert property (active && r.state == EMI_ST_TAIL && r.cnt == 4'h0 |-> dur == want_dur)
    else $error("off-chip access length wrong");
  AST_MODE00_INT: assert property (fire && memory_mode_select == EMI_MODE_INT_ONLY |=> r.state == EMI_ST_INT && r.addr == {4'h0, $past(ea[11:0])})
    else $error("internal mode access left chip");
  AST_MODE11_EXT: assert property (fire && memory_mode_select == EMI_MODE_EXT_ONLY |=> r.state == EMI_ST_LEAD)
    else $error("external mode access stayed on chip");
  AST_HI_UNDRIVEN: assert property (fire && !req_wide && memory_mode_select != EMI_MODE_SPLIT_BS |=> ##1 !addr_hi_oe)
    else $error("upper address driven by 8-bit move");
  AST_BANK_HI: assert property (fire && !go_int && memory_mode_select == EMI_MODE_SPLIT_BS |=> addr_hi_oe == 1'b1 ##0 r.addr == $past(ea))
    else $error("bank select address wrong");

  COV_MUX_WRITE: cover property (r.mux && !wr_n);
  COV_NONMUX_READ: cover property (!r.mux && !rd_n);
  COV_INT_ACCESS: cover property (r.state == EMI_ST_INT_DONE);
  COV_MAX_TIMING: cover property (r.state == EMI_ST_TAIL && r.timing == EMI_TC_RST);

endmodule : emi_core

`default_nettype wire

// file: design/emi_pkg.sv
package emi_pkg;

  // ************************************************************
  // memory modes
  // ************************************************************
  typedef enum logic [1:0] {
    EMI_MODE_INT_ONLY = 2'b00,
    EMI_MODE_SPLIT_NB = 2'b01,
    EMI_MODE_SPLIT_BS = 2'b10,
    EMI_MODE_EXT_ONLY = 2'b11
  } emi_mode_t;

  // ************************************************************
  // access sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    EMI_ST_IDLE     = 4'b0000,
    EMI_ST_INT      = 4'b0001,
    EMI_ST_INT_DONE = 4'b0010,
    EMI_ST_LEAD     = 4'b0011,
    EMI_ST_ALE_HI   = 4'b0100,
    EMI_ST_ALE_LO   = 4'b0101,
    EMI_ST_SETUP    = 4'b0110,
    EMI_ST_STROBE   = 4'b0111,
    EMI_ST_HOLD     = 4'b1000,
    EMI_ST_TAIL     = 4'b1001
  } emi_state_t;

  // ************************************************************
  // timing register layout and reset
  // ************************************************************
  localparam int         EMI_TC_SETUP_LSB  = 6;
  localparam int         EMI_TC_STROBE_LSB = 2;
  localparam int         EMI_TC_HOLD_LSB   = 0;
  localparam logic [7:0] EMI_TC_RST        = 8'hFF;

  // ************************************************************
  // sizes and fixed cycle counts
  // ************************************************************
  localparam int         EMI_EXTERNAL_DATA_RAM_AW   = 12;
  localparam int         EMI_EXTERNAL_DATA_RAM_WORDS = 4096;
  localparam logic [3:0] EMI_OVERHEAD  = 4'h4;
  localparam logic [3:0] EMI_TAIL_CNT  = 4'h2;

endpackage : emi_pkg

// file: design/emi_external_data_ram.sv
`timescale 1ns/100ps
`default_nettype none

module emi_external_data_ram (
  input  wire logic                          clk_sys,
  input  wire logic                          we,
  input  wire logic [emi_pkg::EMI_EXTERNAL_DATA_RAM_AW-1:0] addr,
  input  wire logic [7:0]                    wdata,
  output logic      [7:0]                    rdata
);
  import emi_pkg::*;

  logic [7:0] mem [0:EMI_EXTERNAL_DATA_RAM_WORDS-1];

  // ************************************************************
  // single port, registered read
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : emi_external_data_ram

`default_nettype wire

// file: test/emi_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none

module emi_ext_mem (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  port_hi,
  input  wire logic [7:0]  addr_hi_out,
  input  wire logic        addr_hi_oe,
  input  wire logic [7:0]  addr_lo_out,
  input  wire logic        addr_lo_oe,
  input  wire logic [7:0]  ad_out,
  input  wire logic        ad_oe,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic      [7:0]  ad_in,
  output int               strobe_cnt,
  output int               busy_cnt,
  output logic      [15:0] last_addr,
  output logic             last_hi_oe,
  output int               last_w,
  output int               last_ale
);
  // ************************************************************
  // address latch, memory, pin levels
  // ************************************************************
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat;
  logic [7:0]  last_pin;
  logic [15:0] pa;
  logic        strb;
  int          w;
  int          a;

  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
    strobe_cnt = 0;
    busy_cnt = 0;
    w = 0;
    a = 0;
    last_pin = 8'h00;
  end

  // transparent while ale high, frozen after the fall
  always_latch
    if (ale)
      lat = ad_out;

  // undriven upper pins keep the port latch value
  assign pa = {addr_hi_oe ? addr_hi_out : port_hi, addr_lo_oe ? addr_lo_out : lat};
  assign strb = ~rd_n | ~wr_n;
  // released bus toggles so a stale value never looks valid
  assign ad_in = ~rd_n ? mem[pa] : ~last_pin;

  always @(posedge clk_sys) begin
    last_pin <= ad_in;
    if (ale)
      a <= a + 1;
    if (ale | strb | addr_hi_oe | addr_lo_oe)
      busy_cnt <= busy_cnt + 1;
    if (strb) begin
      w <= w + 1;
      if (!wr_n && ad_oe)
        mem[pa] <= ad_out;
    end
    if (strb && w == 0) begin
      strobe_cnt <= strobe_cnt + 1;
      last_addr <= pa;
      last_hi_oe <= addr_hi_oe;
      last_ale <= a;
      a <= 0;
    end
    if (!strb && w != 0) begin
      last_w <= w;
      w <= 0;
    end
  end
endmodule : emi_ext_mem

`default_nettype wire

// file: test/emi_core_tb.sv
`timescale 1ns/100ps
`default_nettype none

module emi_core_tb;
  import emi_pkg::*;
  typedef struct {int cyc; logic rd; logic chk; logic [7:0] dat; logic ext;
                  logic [15:0] adr; logic hoe; int w; int a;} emi_exp_t;
  logic clk_sys, srst, mux_mode_select, timing_load, req_valid, req_ready, req_write;
  logic req_wide, rsp_valid, addr_hi_oe, addr_lo_oe, ad_oe, ale, rd_n, wr_n, last_hi_oe;
  logic [1:0]  latch_strobe_width_select;
  logic [7:0]  timing_wdata, emif_timing_register, external_data_ram_page_register, byte_pointer;
  logic [7:0]  req_wdata, rsp_rdata, addr_hi_out, addr_lo_out, ad_out, ad_in, port_hi;
  logic [15:0] data_pointer, last_addr;
  emi_mode_t   memory_mode_select;
  int          strobe_cnt, busy_cnt, last_w, last_ale, cyc, s0, b0, n, error_cnt, checks_done;
  emi_exp_t    q[$];
  emi_exp_t    e;
  emi_exp_t    m;
  logic [7:0]  iref [logic [11:0]];
  logic [7:0]  xref [logic [15:0]];
  logic [7:0]  hv [4] = '{8'h00, 8'h0F, 8'h10, 8'hA5};
  logic [7:0]  t_cur, hi, lo;
  logic [1:0]  al_cur, md;
  logic [11:0] idx;
  logic        b2b, mx, wd, wrt;

  emi_core i_dut (.clk_sys(clk_sys), .srst(srst), .mux_mode_select(mux_mode_select),
    .memory_mode_select(memory_mode_select), .latch_strobe_width_select(latch_strobe_width_select),
    .timing_load(timing_load), .timing_wdata(timing_wdata),
    .emif_timing_register(emif_timing_register), .external_data_ram_page_register(external_data_ram_page_register),
    .byte_pointer(byte_pointer), .data_pointer(data_pointer), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_wide(req_wide), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr_hi_out(addr_hi_out),
    .addr_hi_oe(addr_hi_oe), .addr_lo_out(addr_lo_out), .addr_lo_oe(addr_lo_oe),
    .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));

  emi_ext_mem i_mem (.clk_sys(clk_sys), .port_hi(port_hi), .addr_hi_out(addr_hi_out),
    .addr_hi_oe(addr_hi_oe), .addr_lo_out(addr_lo_out), .addr_lo_oe(addr_lo_oe),
    .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in),
    .strobe_cnt(strobe_cnt), .busy_cnt(busy_cnt), .last_addr(last_addr),
    .last_hi_oe(last_hi_oe), .last_w(last_w), .last_ale(last_ale));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, ex, got);
    end
  endtask : check

  task automatic wait_ready();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100)
      check("req_ready", 1, 0);
  endtask : wait_ready

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ************************************************************
  // response monitor
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      m = q.pop_front();
      check("latency", m.cyc, cyc);
      if (m.rd && m.chk)
        check("rdata", m.dat, rsp_rdata);
      check("strobes", m.ext, strobe_cnt - s0);
      if (m.ext) begin
        check("address", m.adr, last_addr);
        check("hi_oe", m.hoe, last_hi_oe);
        check("strobe width", m.w, last_w);
        check("ale width", m.a, last_ale);
      end else
        check("busy", 0, busy_cnt - b0);
      s0 = strobe_cnt;
      b0 = busy_cnt;
    end
  end

  // ************************************************************
  // watchdog
  // ************************************************************
  initial begin
    #800000;
    error_cnt++;
    close_out();
  end

  initial begin
    {clk_sys, mux_mode_select, timing_load, req_valid, req_write, req_wide, b2b} = '0;
    {timing_wdata, external_data_ram_page_register, byte_pointer, req_wdata, data_pointer} = '0;
    {latch_strobe_width_select, al_cur, error_cnt, checks_done} = '0;
    srst = 1'b1;
    port_hi = 8'h00;
    t_cur = 8'hFF;
    memory_mode_select = EMI_MODE_INT_ONLY;
    void'($urandom(32'hC8BE));
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check("timing reset", 8'hFF, emif_timing_register);
    for (int it = 0; it < 80; it++) begin
      if (!b2b) begin
        wait_ready();
        port_hi <= hv[$urandom % 4];
        if (it != 0) begin
          t_cur = 8'($urandom);
          al_cur = 2'($urandom);
          timing_load <= 1'b1;
          timing_wdata <= t_cur;
          latch_strobe_width_select <= al_cur;
          @(posedge clk_sys);
          timing_load <= 1'b0;
          @(posedge clk_sys);
          check("timing", t_cur, emif_timing_register);
        end
      end
      md = 2'($urandom);
      mx = 1'($urandom);
      wd = 1'($urandom);
      wrt = 1'($urandom);
      memory_mode_select <= emi_mode_t'(md);
      mux_mode_select <= mx;
      req_wide <= wd;
      req_write <= wrt;
      external_data_ram_page_register <= hv[$urandom % 4];
      byte_pointer <= 8'($urandom % 4);
      data_pointer <= {hv[$urandom % 4], 8'($urandom % 4)};
      req_wdata <= 8'($urandom);
      req_valid <= 1'b1;
      wait_ready();
      // held while busy, taken at the ready edge
      b2b = it < 79 ? 1'($urandom) : 1'b0;
      if (!b2b)
        req_valid <= 1'b0;
      hi = wd ? data_pointer[15:8] : external_data_ram_page_register;
      lo = wd ? data_pointer[7:0] : byte_pointer;
      idx = {hi[3:0], lo};
      e.ext = md == 2'b11 || (md != 2'b00 && hi >= 8'h10);
      e.hoe = wd || md == 2'b10;
      e.adr = {e.hoe ? hi : port_hi, lo};
      e.cyc = cyc + (e.ext ? 6 + t_cur[7:6] + t_cur[5:2] + t_cur[1:0]
                     + (mx ? 0 : 2 * (al_cur + 1)) : 3);
      e.rd = !wrt;
      e.chk = 1'b1;
      e.w = t_cur[5:2] + 1;
      e.a = mx ? 0 : al_cur + 1;
      e.dat = 8'h00;
      if (wrt && e.ext)
        xref[e.adr] = req_wdata;
      else if (wrt)
        iref[idx] = req_wdata;
      else if (e.ext && xref.exists(e.adr))
        e.dat = xref[e.adr];
      else if (!e.ext && iref.exists(idx))
        e.dat = iref[idx];
      else if (!e.ext)
        e.chk = 1'b0;
      q.push_back(e);
    end
    n = 0;
    while (q.size() != 0 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    check("pending", 0, q.size());
    close_out();
  end
endmodule : emi_core_tb

`default_nettype wire
